// ===== core/tc8_pkg.sv
// Package for the dual 8-bit timer/counter: control field layout, modes, sources.
// Assumes a single 200 MHz system clock; no register bus, ports carry all control.
package tc8_pkg;

    // Control register field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_FF_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // Prescaler taps counted in high-clock ticks; LOW_ taps counted in low-clock ticks
    localparam int PRESCALE_W = 11;
    localparam int TAP_DIV2048 = 10;
    localparam int TAP_DIV128 = 6;
    localparam int TAP_DIV32 = 4;
    localparam int TAP_DIV8 = 2;
    localparam int TAP_DIV2 = 0;
    localparam int LOW_TAP_DIV8 = 2;
    localparam int LOW_PRESCALE_W = 3;

    typedef enum logic [2:0] {
        MODE_TIMER = 3'b000,
        MODE_DIVIDER = 3'b001,
        MODE_PWM = 3'b010,
        MODE_RESERVED = 3'b011
    } mode_t;

    typedef enum logic [2:0] {
        SRC_SLOW = 3'b000,
        SRC_DIV128 = 3'b001,
        SRC_DIV32 = 3'b010,
        SRC_DIV8 = 3'b011,
        SRC_LOW = 3'b100,
        SRC_DIV2 = 3'b101,
        SRC_FULL = 3'b110,
        SRC_EVENT = 3'b111
    } src_t;

    // Channel control register image
    typedef struct packed {
        logic ff_init;
        logic [2:0] src;
        logic run;
        logic [2:0] mode;
    } ctrl_t;

    // Shared tick strobes from the prescaler
    typedef struct packed {
        logic div2048;
        logic div128;
        logic div32;
        logic div8;
        logic div2;
        logic full;
        logic low;
        logic low_div8;
    } ticks_t;

    // Software write port for one channel
    typedef struct packed {
        logic ctrl_we;
        logic cmp_we;
        logic duty_we;
        logic [7:0] data;
    } wr_t;

endpackage

// ===== core/tc8_channel.sv
// One 8-bit timer/counter channel: counter, compare, duty buffer, output flip-flop.
// Assumes tick strobes are one-cycle pulses from the shared prescaler.
`timescale 1ns/1ps
module tc8_channel (
    input wire logic sys_clk,
    input wire logic rst,
    input wire tc8_pkg::ticks_t ticks,
    input wire logic prescaler_source_select,
    input wire logic slow_mode,
    input wire logic event_input_pin,
    input wire tc8_pkg::wr_t wr,
    output logic [7:0] ctrl_rd,
    output logic [7:0] cmp_rd,
    output logic [7:0] duty_rd,
    output logic [7:0] count_rd,
    output logic channel_interrupt,
    output logic divider_output_pin,
    output logic pwm_output_pin
);
    tc8_pkg::ctrl_t ctrl;
    logic [7:0] compare_register;
    logic [7:0] pwm_duty_register;
    logic [7:0] duty_buffer;
    logic [7:0] count;
    logic ff;
    logic event_prev;
    logic tick;
    logic running;
    logic cmp_hit;
    logic duty_hit;
    logic wrap;
    tc8_pkg::mode_t mode;

    assign mode = tc8_pkg::mode_t'(ctrl.mode); // see R20
    assign running = ctrl.run;

    // Source selection per mode
    always_comb begin
        logic slow_tick;
        slow_tick = prescaler_source_select ? ticks.low_div8 : ticks.div2048;
        if (slow_mode) begin
            slow_tick = ticks.low_div8; // see R19
        end
        case (tc8_pkg::src_t'(ctrl.src))
            tc8_pkg::SRC_SLOW: tick = slow_tick; // see R18
            tc8_pkg::SRC_DIV128: tick = ticks.div128 & ~slow_mode;
            tc8_pkg::SRC_DIV32: tick = ticks.div32 & ~slow_mode;
            tc8_pkg::SRC_DIV8: tick = ticks.div8 & ~slow_mode;
            tc8_pkg::SRC_LOW: tick = (mode == tc8_pkg::MODE_PWM) & ticks.low;
            tc8_pkg::SRC_DIV2: tick = (mode == tc8_pkg::MODE_PWM) & ticks.div2 & ~slow_mode;
            tc8_pkg::SRC_FULL: tick = (mode == tc8_pkg::MODE_PWM) & ticks.full & ~slow_mode;
            tc8_pkg::SRC_EVENT: tick = (mode == tc8_pkg::MODE_TIMER)
                                       & event_prev & ~event_input_pin; // see R5
            default: tick = 1'b0;
        endcase
    end

    // Live compare, no staging register
    assign cmp_hit = tick && running && (count == compare_register); // see R2
    assign duty_hit = tick && running && (count == pwm_duty_register);
    assign wrap = tick && running && (count == tc8_pkg::CNT_MAX);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            event_prev <= 1'b1;
        end else begin
            event_prev <= event_input_pin;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= tc8_pkg::ctrl_t'(tc8_pkg::CTRL_RESET);
        end else if (wr.ctrl_we) begin
            ctrl <= tc8_pkg::ctrl_t'(wr.data); // see R11
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            compare_register <= tc8_pkg::CMP_RESET;
        end else if (wr.cmp_we) begin
            compare_register <= wr.data; // see R2
        end
    end

    // Duty double buffer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            duty_buffer <= tc8_pkg::DUTY_RESET;
        end else if (wr.duty_we) begin
            duty_buffer <= wr.data; // see R14
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwm_duty_register <= tc8_pkg::DUTY_RESET;
        end else if (mode == tc8_pkg::MODE_PWM && running && wrap) begin
            pwm_duty_register <= duty_buffer; // see R14
        end else if (!running || mode != tc8_pkg::MODE_PWM) begin
            pwm_duty_register <= duty_buffer; // see R14
        end
    end

    // Counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
        end else if (!running) begin
            count <= 8'h00;
        end else if (mode == tc8_pkg::MODE_PWM) begin
            if (wrap) begin
                count <= 8'h00; // see R12
            end else if (tick) begin
                count <= count + 8'h01;
            end
        end else if (mode == tc8_pkg::MODE_RESERVED) begin
            count <= count;
        end else if (cmp_hit) begin
            count <= 8'h00; // see R1, R5, R7
        end else if (tick) begin
            count <= count + 8'h01; // see R1
        end
    end

    // Output flip-flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ff <= 1'b0; // see R8, R13
        end else if (wr.ctrl_we && !wr.data[tc8_pkg::CTRL_RUN_BIT] && !running) begin
            ff <= wr.data[tc8_pkg::CTRL_FF_BIT]; // see R8, R11
        end else if (wr.ctrl_we && running) begin
            ff <= ff; // see R10
        end else if (running && mode == tc8_pkg::MODE_DIVIDER && cmp_hit) begin
            ff <= ~ff; // see R7
        end else if (running && mode == tc8_pkg::MODE_PWM && (duty_hit ^ wrap)) begin
            ff <= ~ff; // see R12
        end
    end

    // Interrupt pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            channel_interrupt <= 1'b0;
        end else if (mode == tc8_pkg::MODE_PWM) begin
            channel_interrupt <= wrap; // see R12
        end else if (mode == tc8_pkg::MODE_RESERVED) begin
            channel_interrupt <= 1'b0;
        end else begin
            channel_interrupt <= cmp_hit; // see R1, R5, R7
        end
    end

    always_comb begin
        ctrl_rd = ctrl;
        cmp_rd = compare_register;
        duty_rd = (mode == tc8_pkg::MODE_PWM) ? pwm_duty_register : duty_buffer; // see R15
        count_rd = count;
        divider_output_pin = ~ff; // see R8
        pwm_output_pin = ~ff; // see R13
    end
endmodule

// ===== core/tc8_dual.sv
// Top of the dual 8-bit timer/counter: shared prescaler and two channels.
// Assumes software writes arrive as single-cycle strobes; inputs synchronous to sys_clk.
`timescale 1ns/1ps

// Functional notes
// R1: Timer mode counts ticks; on compare match interrupt, clear, keep counting.
// R2: Compare register is live in timer, event and divider modes.
// R3: Software leaves compare alone while running in those modes.
// R4: Software keeps flip-flop initial bit zero in timer mode.
// R5: Event mode counts falling edges; match interrupts, clears, resumes.
// R6: Event source holds each phase at least two machine cycles.
// R7: Divider mode toggles flip-flop on match, clears counter, interrupts.
// R8: Divider pin is inverse flip-flop; preloadable; reset clears flip-flop.
// R9: Software sets the port output latch to one before use.
// R10: Stopping holds the pin; flip-flop rewritten only after the stop.
// R11: Control bit 3 is run, bit 7 is flip-flop initial value.
// R12: PWM toggles on duty match, toggles on overflow, clears, interrupts.
// R13: PWM pin is inverse flip-flop; initial value sets polarity; reset clears.
// R14: Duty writes buffered; transferred at interrupt, or at once when stopped.
// R15: Duty read during PWM returns the value in effect.
// R16: Software writes duty soon after the interrupt.
// R17: Software stops PWM before the low-power stop state.
// R18: PWM sources: slow tap, /128, /32, /8, low clock, /2, full.
// R19: Timer sources slow tap, /128, /32, /8; slow states only low/8.
// R20: Mode 000 timer/event, 001 divider, 010 PWM, 011 reserved.
// R21: Two independent identical channels.
module tc8_dual (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic high_clk_tick,
    input wire logic low_clk_tick,
    input wire logic prescaler_source_select,
    input wire logic slow_mode,
    input wire logic [1:0] event_input_pin,
    input wire tc8_pkg::wr_t wr0,
    input wire tc8_pkg::wr_t wr1,
    output logic [7:0] ctrl0_rd,
    output logic [7:0] cmp0_rd,
    output logic [7:0] duty0_rd,
    output logic [7:0] count0_rd,
    output logic [7:0] ctrl1_rd,
    output logic [7:0] cmp1_rd,
    output logic [7:0] duty1_rd,
    output logic [7:0] count1_rd,
    output logic [1:0] channel_interrupt,
    output logic [1:0] divider_output_pin,
    output logic [1:0] pwm_output_pin
);
    logic [tc8_pkg::PRESCALE_W-1:0] hi_div;
    logic [tc8_pkg::LOW_PRESCALE_W-1:0] lo_div;
    tc8_pkg::ticks_t ticks;
    logic [1:0] irq_c;
    logic [1:0] pdo_c;
    logic [1:0] pwm_c;
    logic [7:0] rd_c [0:1][0:3];
    tc8_pkg::wr_t wr_c [0:1];

    // Prescaler chains on the system clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hi_div <= '0;
        end else if (high_clk_tick) begin
            hi_div <= hi_div + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lo_div <= '0;
        end else if (low_clk_tick) begin
            lo_div <= lo_div + 1'b1;
        end
    end

    // Tick when the tap bit is about to carry out
    always_comb begin
        ticks.full = high_clk_tick;
        ticks.div2 = high_clk_tick & (&hi_div[tc8_pkg::TAP_DIV2:0]);
        ticks.div8 = high_clk_tick & (&hi_div[tc8_pkg::TAP_DIV8:0]);
        ticks.div32 = high_clk_tick & (&hi_div[tc8_pkg::TAP_DIV32:0]);
        ticks.div128 = high_clk_tick & (&hi_div[tc8_pkg::TAP_DIV128:0]);
        ticks.div2048 = high_clk_tick & (&hi_div[tc8_pkg::TAP_DIV2048:0]);
        ticks.low = low_clk_tick;
        ticks.low_div8 = low_clk_tick & (&lo_div[tc8_pkg::LOW_TAP_DIV8:0]);
    end

    assign wr_c[0] = wr0;
    assign wr_c[1] = wr1;

    // see R21
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            tc8_channel u_ch (
                .sys_clk(sys_clk),
                .rst(rst),
                .ticks(ticks),
                .prescaler_source_select(prescaler_source_select),
                .slow_mode(slow_mode),
                .event_input_pin(event_input_pin[ch]),
                .wr(wr_c[ch]),
                .ctrl_rd(rd_c[ch][0]),
                .cmp_rd(rd_c[ch][1]),
                .duty_rd(rd_c[ch][2]),
                .count_rd(rd_c[ch][3]),
                .channel_interrupt(irq_c[ch]),
                .divider_output_pin(pdo_c[ch]),
                .pwm_output_pin(pwm_c[ch])
            );
        end
    endgenerate

    // Output registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            channel_interrupt <= 2'h0;
            divider_output_pin <= 2'h3;
            pwm_output_pin <= 2'h3;
        end else begin
            channel_interrupt <= irq_c;
            divider_output_pin <= pdo_c;
            pwm_output_pin <= pwm_c;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl0_rd <= 8'h00;
            cmp0_rd <= 8'h00;
            duty0_rd <= 8'h00;
            count0_rd <= 8'h00;
            ctrl1_rd <= 8'h00;
            cmp1_rd <= 8'h00;
            duty1_rd <= 8'h00;
            count1_rd <= 8'h00;
        end else begin
            ctrl0_rd <= rd_c[0][0];
            cmp0_rd <= rd_c[0][1];
            duty0_rd <= rd_c[0][2];
            count0_rd <= rd_c[0][3];
            ctrl1_rd <= rd_c[1][0];
            cmp1_rd <= rd_c[1][1];
            duty1_rd <= rd_c[1][2];
            count1_rd <= rd_c[1][3];
        end
    end
endmodule

// ===== verification/tc8_event_src.sv
// Event pulse source standing in for the external device on an event pin.
// Assumes fire is raised off the falling edge; the line idles high by a pull-up.
`timescale 1ns/1ps
module tc8_event_src #(
    parameter int HOLD = 2
) (
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic [7:0] pulses,
    output logic pin,
    output logic busy
);
    initial begin
        pin = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (fire === 1'b1) begin
                busy = 1'b1;
                repeat (pulses) begin
                    @(negedge sys_clk);
                    pin = 1'b0;
                    repeat (HOLD) @(negedge sys_clk);
                    pin = 1'b1;
                    repeat (HOLD - 1) @(negedge sys_clk);
                end
                busy = 1'b0;
            end
        end
    end
endmodule

// ===== verification/tc8_dual_sva.sv
// Checker for the dual 8-bit timer/counter, bound to the top module's ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module tc8_dual_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] ctrl0_rd,
    input wire logic [7:0] cmp0_rd,
    input wire logic [7:0] count0_rd,
    input wire logic [7:0] ctrl1_rd,
    input wire logic [1:0] channel_interrupt,
    input wire logic [1:0] divider_output_pin,
    input wire logic [1:0] pwm_output_pin
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_irq_pulse;
        channel_interrupt[0] |=> !channel_interrupt[0];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq0 too long");
    property p_irq_pulse1;
        channel_interrupt[1] |=> !channel_interrupt[1];
    endproperty
    a_irq_pulse1: assert property (p_irq_pulse1) else $error("irq1 too long");
    property p_irq_clears;
        channel_interrupt[0] |-> count0_rd == 8'h00;
    endproperty
    a_irq_clears: assert property (p_irq_clears) else $error("count not cleared");
    property p_count_step;
        $changed(count0_rd) |-> count0_rd == 8'($past(count0_rd) + 8'h01) || count0_rd == 8'h00;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count jumped");
    property p_count_bound;
        ctrl0_rd[3] && ctrl0_rd[2:1] == 2'b00 && $stable(ctrl0_rd) && $stable(cmp0_rd)
            |-> count0_rd <= cmp0_rd;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("count past compare");
    property p_stop_quiet;
        !ctrl0_rd[3] [*3] |-> count0_rd == 8'h00 && !channel_interrupt[0];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stopped channel active");
    property p_stop_hold;
        !ctrl0_rd[3] && $stable(ctrl0_rd) |-> $stable(divider_output_pin[0]);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("pin moved while stopped");
    property p_div_toggle;
        channel_interrupt[0] && ctrl0_rd[2:0] == 3'h1
            |-> divider_output_pin[0] != $past(divider_output_pin[0]);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("no divider toggle");
    property p_pwm_toggle;
        channel_interrupt[1] && ctrl1_rd[2:0] == 3'h2
            |-> pwm_output_pin[1] != $past(pwm_output_pin[1]);
    endproperty
    a_pwm_toggle: assert property (p_pwm_toggle) else $error("no overflow toggle");
    property p_pins_same;
        divider_output_pin == pwm_output_pin;
    endproperty
    a_pins_same: assert property (p_pins_same) else $error("pins disagree");

    c_div_irq: cover property (channel_interrupt[0] && ctrl0_rd[2:0] == 3'h1);
    c_pwm_irq: cover property (channel_interrupt[1] && ctrl1_rd[2:0] == 3'h2);
    c_event_irq: cover property (channel_interrupt[1] && ctrl1_rd[6:4] == 3'h7);
endmodule

// ===== verification/tb_tc8_dual.sv
// Testbench for the dual 8-bit timer/counter: timer, event, divider, PWM, reserved mode.
// Assumes tc8_pkg, the checker and the event source model are compiled first.
`timescale 1ns/1ps
module tb_tc8_dual;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic high_clk_tick = 1'b0;
    logic low_clk_tick = 1'b0;
    logic prescaler_source_select = 1'b0;
    logic slow_mode = 1'b0;
    wire [1:0] event_input_pin;
    tc8_pkg::wr_t wr0 = '0;
    tc8_pkg::wr_t wr1 = '0;
    logic [7:0] ctrl0_rd, cmp0_rd, duty0_rd, count0_rd, ctrl1_rd, cmp1_rd, duty1_rd, count1_rd;
    logic [1:0] channel_interrupt, divider_output_pin, pwm_output_pin;
    wire [1:0] busy;
    logic [1:0] fire = 2'b00;
    logic [7:0] pulses = 8'h00;
    logic [2:0] ph = 3'h0;
    int miscompares = 0;
    int checks_done = 0;
    int irq_n0 = 0;
    int irq_n1 = 0;

    tc8_dual dut (.sys_clk, .rst, .high_clk_tick, .low_clk_tick, .prescaler_source_select,
        .slow_mode, .event_input_pin, .wr0, .wr1, .ctrl0_rd, .cmp0_rd, .duty0_rd, .count0_rd,
        .ctrl1_rd, .cmp1_rd, .duty1_rd, .count1_rd, .channel_interrupt, .divider_output_pin,
        .pwm_output_pin);
    tc8_event_src #(.HOLD(5)) src0 (.sys_clk, .fire(fire[0]), .pulses,
        .pin(event_input_pin[0]), .busy(busy[0]));
    tc8_event_src #(.HOLD(2)) src1 (.sys_clk, .fire(fire[1]), .pulses,
        .pin(event_input_pin[1]), .busy(busy[1]));

    initial forever #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        ph <= ph + 3'h1;
        high_clk_tick <= ~ph[0];
        low_clk_tick <= (ph == 3'h7);
        if (channel_interrupt[0] === 1'b1) irq_n0++;
        if (channel_interrupt[1] === 1'b1) irq_n1++;
    end

    task print_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task stuck(input bit c);
        if (c) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input bit ch, input logic [2:0] we, input logic [7:0] d);
        @(negedge sys_clk);
        if (ch) wr1 = tc8_pkg::wr_t'({we, d});
        else wr0 = tc8_pkg::wr_t'({we, d});
        @(negedge sys_clk);
        wr0 = '0;
        wr1 = '0;
        @(negedge sys_clk);
    endtask
    task pulse(input int ch, input logic [7:0] cnt);
        int k;
        @(negedge sys_clk);
        pulses = cnt;
        fire[ch] = 1'b1;
        @(negedge sys_clk);
        fire[ch] = 1'b0;
        for (k = 0; k < 500 && busy[ch] !== 1'b0; k++) @(posedge sys_clk);
        stuck(k >= 500);
        repeat (4) @(negedge sys_clk);
    endtask
    // Cycles from one interrupt of a channel to its next one
    task gap(input int ch, output int n);
        int k;
        for (k = 0; k < 3000 && channel_interrupt[ch] !== 1'b1; k++) @(negedge sys_clk);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (channel_interrupt[ch] !== 1'b1 && n < 3000);
        stuck(k >= 3000 || n >= 3000);
    endtask
    // Length of the next full level on the channel 1 PWM pin
    task run_len(output int n);
        int k;
        logic v;
        v = pwm_output_pin[1];
        for (k = 0; k < 3000 && pwm_output_pin[1] === v; k++) @(negedge sys_clk);
        v = pwm_output_pin[1];
        for (n = 0; n < 3000 && pwm_output_pin[1] === v; n++) @(negedge sys_clk);
        stuck(k >= 3000 || n >= 3000);
    endtask

    task t_reset;
        check("regs after reset", 16'h0000, {ctrl0_rd | cmp0_rd | duty0_rd | count0_rd,
            ctrl1_rd | cmp1_rd | duty1_rd | count1_rd});
        check("pins after reset", 16'h000F, {12'h000, divider_output_pin, pwm_output_pin});
    endtask
    task t_timer;
        int n;
        wr(0, 3'b100, 8'h30);
        wr(0, 3'b010, 8'h03);
        check("compare", 16'h0003, {8'h00, cmp0_rd});
        wr(0, 3'b100, 8'h38);
        gap(0, n);
        check("timer period", 16'd64, 16'(n));
        check("timer clear and pin", 16'h0100, {7'h00, divider_output_pin[0], count0_rd});
        wr(0, 3'b100, 8'h30);
        prescaler_source_select = 1'b1;
        slow_mode = 1'b1;
        wr(0, 3'b010, 8'h01);
        wr(0, 3'b100, 8'h08);
        gap(0, n);
        check("slow timer period", 16'd128, 16'(n));
        wr(0, 3'b100, 8'h00);
        prescaler_source_select = 1'b0;
        slow_mode = 1'b0;
    endtask
    task t_event;
        int k;
        int j;
        wr(1, 3'b010, 8'h03);
        wr(1, 3'b100, 8'h70);
        wr(1, 3'b100, 8'h78);
        check("event setup", 16'h7803, {ctrl1_rd, cmp1_rd});
        k = irq_n1;
        j = irq_n0;
        pulse(1, 8'h03);
        check("events below match", 16'h0003, {8'(irq_n1 - k), count1_rd});
        pulse(1, 8'h01);
        check("event match", 16'h0100, {8'(irq_n1 - k), count1_rd});
        check("other channel idle", 16'h0000, {8'(irq_n0 - j), count0_rd});
        wr(1, 3'b100, 8'h70);
    endtask
    task t_divider;
        int n;
        int k;
        wr(0, 3'b100, 8'h31);
        wr(0, 3'b010, 8'h01);
        wr(0, 3'b100, 8'h39);
        gap(0, n);
        check("divider half period", 16'd32, 16'(n));
        @(negedge sys_clk);
        for (k = 0; k < 100 && channel_interrupt[0] !== 1'b1; k++) @(negedge sys_clk);
        stuck(k >= 100);
        wr(0, 3'b100, 8'h31);
        repeat (40) @(negedge sys_clk);
        check("pin held after stop", 16'h0000, {15'h0000, divider_output_pin[0]});
        wr(0, 3'b100, 8'h01);
        check("bit 7 cleared", 16'h0001, {15'h0000, divider_output_pin[0]});
        wr(0, 3'b100, 8'h81);
        check("bit 7 set", 16'h0000, {15'h0000, divider_output_pin[0]});
        wr(0, 3'b100, 8'h01);
    endtask
    task t_pwm;
        int n;
        wr(1, 3'b100, 8'h62);
        wr(1, 3'b001, 8'h40);
        @(negedge sys_clk);
        check("duty while stopped", 16'h0040, {8'h00, duty1_rd});
        wr(1, 3'b100, 8'h6A);
        wr(1, 3'b001, 8'h80);
        check("duty before transfer", 16'h0040, {8'h00, duty1_rd});
        gap(1, n);
        check("pwm period", 16'd512, 16'(n));
        check("duty after transfer", 16'h0080, {8'h00, duty1_rd});
        run_len(n);
        check("pwm low time", 16'd254, 16'(n));
        wr(1, 3'b100, 8'h62);
    endtask
    task t_reserved;
        int k;
        k = irq_n0;
        wr(0, 3'b100, 8'h3B);
        repeat (100) @(negedge sys_clk);
        check("reserved mode", 16'h0000, {8'(irq_n0 - k), count0_rd});
        wr(0, 3'b100, 8'h33);
    endtask
    // Remaining timer sources (/128, /32) and the low-clock and /2 PWM sources, checked by period
    task t_sources;
        int n;
        wr(0, 3'b010, 8'h01);
        wr(0, 3'b100, 8'h18);
        gap(0, n);
        check("div128 timer period", 16'd512, 16'(n));
        wr(0, 3'b100, 8'h20);
        wr(0, 3'b100, 8'h28);
        gap(0, n);
        check("div32 timer period", 16'd128, 16'(n));
        wr(0, 3'b100, 8'h00);
        wr(1, 3'b100, 8'h42);
        wr(1, 3'b100, 8'h4A);
        gap(1, n);
        check("low clock pwm period", 16'd2048, 16'(n));
        wr(1, 3'b100, 8'h52);
        wr(1, 3'b100, 8'h5A);
        gap(1, n);
        check("half clock pwm period", 16'd1024, 16'(n));
        wr(1, 3'b100, 8'h52);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_reset();
        t_timer();
        t_event();
        t_divider();
        t_pwm();
        t_reserved();
        t_sources();
        print_verdict();
    end
endmodule

bind tc8_dual tc8_dual_sva u_sva (.sys_clk, .rst, .ctrl0_rd, .cmp0_rd, .count0_rd, .ctrl1_rd,
    .channel_interrupt, .divider_output_pin, .pwm_output_pin);
